// ==== shared/mcs_params.svh ====
// offsets, field positions, reset values of the mac slice
// assumes a 32-bit apb master and a single 125 MHz clock
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_CFG_OFS      8'h00
`define MCS_ACC_OFS      8'h04
`define MCS_FLAG_OFS     8'h08

`define MCS_CFG_SPLIT    0
`define MCS_CFG_INREG    1
`define MCS_CFG_MIDREG   2
`define MCS_CFG_FUNC_LO  3
`define MCS_CFG_FUNC_HI  4
`define MCS_CFG_CASSEL   5
`define MCS_CFG_SIGNED   6
`define MCS_CFG_W        7

`define MCS_CFG_RST      7'h06

`endif

// ==== shared/mcs_pkg.sv ====
// types of the mac slice
// assumes nothing beyond the params header
package mcs_pkg;
    // adder source selection
    typedef enum logic [1:0] {
        MCS_MUL,
        MCS_MAC,
        MCS_ADD,
        MCS_ACC
    } mcs_func_e;
endpackage

// ==== design/mcs_slice.sv ====
// multiply-accumulate slice with apb configuration and status
// assumes fabric drives all pin inputs synchronous to clk
//
// The placing of the registers and the APB register port are this design's own decisions.
`include "mcs_params.svh"

module mcs_slice #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // operands
    input  wire logic          ce,
    input  wire logic [15:0]   op1,
    input  wire logic [15:0]   op2,
    input  wire logic [15:0]   op3,
    input  wire logic [15:0]   op4,
    input  wire logic          op1_hold,
    input  wire logic          op2_hold,
    input  wire logic          op3_hold,
    input  wire logic          op4_hold,
    input  wire logic          upper_input_reset,
    input  wire logic          lower_input_reset,
    // accumulator controls
    input  wire logic          upper_acc_hold,
    input  wire logic          upper_acc_reset,
    input  wire logic          upper_acc_load,
    input  wire logic          upper_add_sub_sel,
    input  wire logic          lower_acc_hold,
    input  wire logic          lower_acc_reset,
    input  wire logic          lower_acc_load,
    input  wire logic          lower_add_sub_sel,
    // cascade
    input  wire logic          cascade_carry_in,
    input  wire logic          tile_carry_in,
    input  wire logic          sign_ext_in_a,
    output logic               cascade_carry_out,
    output logic               tile_carry_out,
    output logic               sign_ext_out_b,
    // result
    output logic      [31:0]   result
);

    function automatic logic [15:0] mul8(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic       sgn);
        logic [15:0] xe;
        logic [15:0] ye;
        xe = {{8{sgn & x[7]}}, x};
        ye = {{8{sgn & y[7]}}, y};
        mul8 = 16'(xe * ye);
    endfunction

    function automatic logic [31:0] mul16(input logic [15:0] x,
                                          input logic [15:0] y,
                                          input logic        sgn);
        logic [31:0] xe;
        logic [31:0] ye;
        xe = {{16{sgn & x[15]}}, x};
        ye = {{16{sgn & y[15]}}, y};
        mul16 = 32'(xe * ye);
    endfunction

    logic [`MCS_CFG_W-1:0] cfg_r;
    logic [15:0]           op1_r;
    logic [15:0]           op2_r;
    logic [15:0]           op3_r;
    logic [15:0]           op4_r;
    logic [15:0]           hh_r;
    logic [15:0]           ll_r;
    logic [31:0]           full_r;
    logic [15:0]           acc_hi_r;
    logic [15:0]           acc_lo_r;
    logic [15:0]           a_s;
    logic [15:0]           b_s;
    logic [15:0]           c_s;
    logic [15:0]           d_s;
    logic [31:0]           prod;
    logic [31:0]           x_full;
    logic [31:0]           y_full;
    logic [15:0]           x_lo;
    logic [15:0]           x_hi;
    logic [16:0]           sum_lo;
    logic [16:0]           sum_hi;
    logic                  cin_raw;
    logic                  cin_hi_raw;
    logic                  cout_lo;
    logic                  cout_hi;
    logic                  split;
    logic                  sgn;
    logic                  wr_en;
    mcs_pkg::mcs_func_e    func;

    assign split = cfg_r[`MCS_CFG_SPLIT];
    assign sgn   = cfg_r[`MCS_CFG_SIGNED];
    assign func  = mcs_pkg::mcs_func_e'(
                       cfg_r[`MCS_CFG_FUNC_HI:`MCS_CFG_FUNC_LO]);
    assign wr_en = psel && penable && pready && pwrite;

    // apb answer one cycle after setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    `MCS_CFG_OFS:  prdata <= 32'(cfg_r);
                    `MCS_ACC_OFS:  prdata <= result;
                    `MCS_FLAG_OFS: prdata <= {28'h000_0000, sign_ext_in_a,
                                              sign_ext_out_b,
                                              tile_carry_out,
                                              cascade_carry_out};
                    default:       pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `MCS_CFG_RST;
        end else if (wr_en && paddr == `MCS_CFG_OFS) begin
            cfg_r <= pwdata[`MCS_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op1_r <= 16'h0000;
            op3_r <= 16'h0000;
        end else if (upper_input_reset) begin
            op1_r <= 16'h0000;
            op3_r <= 16'h0000;
        end else if (ce) begin
            if (!op1_hold) begin
                op1_r <= op1;
            end
            if (!op3_hold) begin
                op3_r <= op3;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op2_r <= 16'h0000;
            op4_r <= 16'h0000;
        end else if (lower_input_reset) begin
            op2_r <= 16'h0000;
            op4_r <= 16'h0000;
        end else if (ce) begin
            if (!op2_hold) begin
                op2_r <= op2;
            end
            if (!op4_hold) begin
                op4_r <= op4;
            end
        end
    end

    assign a_s = cfg_r[`MCS_CFG_INREG] ? op1_r : op1;
    assign b_s = cfg_r[`MCS_CFG_INREG] ? op2_r : op2;
    assign c_s = cfg_r[`MCS_CFG_INREG] ? op3_r : op3;
    assign d_s = cfg_r[`MCS_CFG_INREG] ? op4_r : op4;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hh_r <= 16'h0000;
        end else if (upper_input_reset) begin
            hh_r <= 16'h0000;
        end else if (ce) begin
            hh_r <= mul8(a_s[15:8], b_s[15:8], sgn);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ll_r   <= 16'h0000;
            full_r <= 32'h0000_0000;
        end else if (lower_input_reset) begin
            ll_r   <= 16'h0000;
            full_r <= 32'h0000_0000;
        end else if (ce) begin
            ll_r   <= mul8(a_s[7:0], b_s[7:0], sgn);
            full_r <= mul16(a_s, b_s, sgn);
        end
    end

    always_comb begin
        if (cfg_r[`MCS_CFG_MIDREG]) begin
            prod = split ? {hh_r, ll_r} : full_r;
        end else begin
            prod = split ? {mul8(a_s[15:8], b_s[15:8], sgn),
                            mul8(a_s[7:0], b_s[7:0], sgn)}
                         : mul16(a_s, b_s, sgn);
        end
        unique case (func)
            mcs_pkg::MCS_MUL: begin
                x_full = prod;
                y_full = 32'h0000_0000;
            end
            mcs_pkg::MCS_MAC: begin
                x_full = prod;
                y_full = result;
            end
            mcs_pkg::MCS_ADD: begin
                x_full = {a_s, b_s};
                y_full = {c_s, d_s};
            end
            mcs_pkg::MCS_ACC: begin
                x_full = {a_s, b_s};
                y_full = result;
            end
        endcase
    end

    assign cin_raw = cfg_r[`MCS_CFG_CASSEL] ? cascade_carry_in
                                            : tile_carry_in;
    assign x_lo   = lower_add_sub_sel ? ~x_full[15:0] : x_full[15:0];
    assign sum_lo = {1'b0, y_full[15:0]} + {1'b0, x_lo}
                  + {16'h0000, cin_raw ^ lower_add_sub_sel};
    assign cout_lo = sum_lo[16] ^ lower_add_sub_sel;
    assign cin_hi_raw = split ? 1'b0 : cout_lo;
    assign x_hi   = upper_add_sub_sel ? ~x_full[31:16] : x_full[31:16];
    assign sum_hi = {1'b0, y_full[31:16]} + {1'b0, x_hi}
                  + {16'h0000, cin_hi_raw ^ upper_add_sub_sel};
    assign cout_hi = sum_hi[16] ^ upper_add_sub_sel;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_hi_r          <= 16'h0000;
            cascade_carry_out <= 1'b0;
            sign_ext_out_b    <= 1'b0;
        end else if (upper_acc_reset) begin
            acc_hi_r          <= 16'h0000;
            cascade_carry_out <= 1'b0;
            sign_ext_out_b    <= 1'b0;
        end else if (ce && !upper_acc_hold) begin
            acc_hi_r          <= upper_acc_load ? c_s : sum_hi[15:0];
            cascade_carry_out <= cout_hi;
            sign_ext_out_b    <= sgn ? sum_hi[15] : sign_ext_in_a;
        end
    end

    assign result = {acc_hi_r, acc_lo_r};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_lo_r       <= 16'h0000;
            tile_carry_out <= 1'b0;
        end else if (lower_acc_reset) begin
            acc_lo_r       <= 16'h0000;
            tile_carry_out <= 1'b0;
        end else if (ce && !lower_acc_hold) begin
            acc_lo_r       <= lower_acc_load ? c_s : sum_lo[15:0];
            tile_carry_out <= split ? cout_lo : cout_hi;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_apb_ready_one: assert property (s_setup ##1 s_access |-> pready)
        else $error("apb answer not in first access cycle");
    a_op3_hold_keeps: assert property (
        ce && op3_hold && !upper_input_reset |=> $stable(op3_r))
        else $error("op3 register changed under hold");
    a_op4_loads_data: assert property (
        ce && !op4_hold && !lower_input_reset |=> op4_r == $past(op4))
        else $error("op4 register missed new data");
    a_upper_in_clear: assert property (
        upper_input_reset |=> op1_r == 16'h0000 && op3_r == 16'h0000
                              && hh_r == 16'h0000)
        else $error("upper input registers not cleared");
    a_lower_in_clear: assert property (
        lower_input_reset |=> op2_r == 16'h0000 && op4_r == 16'h0000
                              && ll_r == 16'h0000 && full_r == 32'h0)
        else $error("lower input registers not cleared");
    a_upper_acc_hold: assert property (
        upper_acc_hold && !upper_acc_reset |=> $stable(result[31:16]))
        else $error("upper accumulator moved under hold");
    a_upper_acc_clear: assert property (
        upper_acc_reset |=> result[31:16] == 16'h0000)
        else $error("upper accumulator not cleared");
    a_upper_acc_load: assert property (
        ce && upper_acc_load && !upper_acc_hold && !upper_acc_reset
        |=> result[31:16] == $past(c_s))
        else $error("upper accumulator load wrong");
    a_lower_acc_hold: assert property (
        lower_acc_hold && !lower_acc_reset |=> $stable(result[15:0]))
        else $error("lower accumulator moved under hold");
    a_lower_acc_clear: assert property (
        lower_acc_reset |=> result[15:0] == 16'h0000)
        else $error("lower accumulator not cleared");
    a_lower_sub_sum: assert property (
        ce && lower_add_sub_sel && !lower_acc_load && !lower_acc_hold
        && !lower_acc_reset
        |=> result[15:0] == 16'($past(y_full[15:0]) - $past(x_full[15:0])
                                - {15'h0000, $past(cin_raw)}))
        else $error("lower subtract result wrong");
    a_idle_no_move: assert property (
        !ce && !upper_acc_reset && !lower_acc_reset |=> $stable(result))
        else $error("accumulator moved with ce low");

endmodule // mcs_slice

// ==== bench/mcs_fabric_model.sv ====
// fabric logic and neighbour slices seen from the slice pins
// assumes the bench sets the request levels after a rising edge
module mcs_fabric_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // requests from the bench
    input  wire logic casc_req,
    input  wire logic tile_req,
    input  wire logic sign_req,
    // slice pins
    output logic      cascade_carry_in,
    output logic      tile_carry_in,
    output logic      sign_ext_in_a
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cascade_carry_in <= 1'b0;
            tile_carry_in    <= 1'b0;
        end else begin
            cascade_carry_in <= casc_req;
            tile_carry_in    <= tile_req;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sign_ext_in_a <= 1'b0;
        end else begin
            sign_ext_in_a <= sign_req;
        end
    end
endmodule // mcs_fabric_model

// ==== bench/tb.sv ====
// testbench of the mac slice: apb tasks, pin stimulus, checks
// assumes zero wait apb answers and default cfg after reset
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, result, rd;
    logic        pready, pslverr, err, timed_out = 1'b0;
    logic [15:0] op1 = 16'h0, op2 = 16'h0, op3 = 16'h0, op4 = 16'h0;
    logic        op1_hold = 1'b0, op2_hold = 1'b0, op3_hold = 1'b0;
    logic        op4_hold = 1'b0, upper_input_reset = 1'b0;
    logic        lower_input_reset = 1'b0, upper_acc_hold = 1'b0;
    logic        upper_acc_reset = 1'b0, upper_acc_load = 1'b0;
    logic        upper_add_sub_sel = 1'b0, lower_acc_hold = 1'b0;
    logic        lower_acc_reset = 1'b0, lower_acc_load = 1'b0;
    logic        lower_add_sub_sel = 1'b0, casc_req = 1'b0;
    logic        tile_req = 1'b0, sign_req = 1'b0;
    logic        cascade_carry_in, tile_carry_in, sign_ext_in_a;
    logic        cascade_carry_out, tile_carry_out, sign_ext_out_b;
    int          fail_count = 0, samples_checked = 0;

    always #4 clk = ~clk;

    mcs_slice #(.AW(8)) mcs_slice_inst (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ce, .op1, .op2, .op3, .op4,
        .op1_hold, .op2_hold, .op3_hold, .op4_hold,
        .upper_input_reset, .lower_input_reset, .upper_acc_hold,
        .upper_acc_reset, .upper_acc_load, .upper_add_sub_sel,
        .lower_acc_hold, .lower_acc_reset, .lower_acc_load,
        .lower_add_sub_sel, .cascade_carry_in, .tile_carry_in,
        .sign_ext_in_a, .cascade_carry_out, .tile_carry_out,
        .sign_ext_out_b, .result
    );

    mcs_fabric_model mcs_fabric_model_inst (
        .clk, .rst_n, .casc_req, .tile_req, .sign_req,
        .cascade_carry_in, .tile_carry_in, .sign_ext_in_a
    );

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check_word(input logic [31:0] got,
                              input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        timed_out = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        @(posedge timed_out);
        fail_count++;
        stop_test();
    end

    initial begin
        step(16);
        rst_n <= 1'b1;
        step(1);
        apb(8'h00, 1'b0, 32'h0);
        check_word(rd, 32'h00000006); // cfg default
        apb(8'h0c, 1'b0, 32'h0);
        check_bit(err, 1'b1); // unmapped error
        check_word(rd, 32'h0); // unmapped data
        op1 <= 16'h1234;
        op2 <= 16'h0056;
        step(4);
        check_word(result, 32'h00061d78); // product
        apb(8'h04, 1'b0, 32'h0);
        check_word(rd, 32'h00061d78); // read back
        ce  <= 1'b0;
        op1 <= 16'h0002;
        step(4);
        check_word(result, 32'h00061d78); // frozen
        ce       <= 1'b1;
        op1_hold <= 1'b1;
        step(4);
        check_word(result, 32'h00061d78); // held
        op1_hold <= 1'b0;
        step(4);
        check_word(result, 32'h000000ac); // updated
        upper_input_reset <= 1'b1;
        op1_hold          <= 1'b1;
        step(4);
        check_word(result, 32'h0); // upper cleared
        upper_input_reset <= 1'b0;
        step(4);
        check_word(result, 32'h0); // reset beat hold
        op1_hold          <= 1'b0;
        lower_input_reset <= 1'b1;
        step(4);
        check_word(result, 32'h0); // lower cleared
        lower_input_reset <= 1'b0;
        step(4);
        check_word(result, 32'h000000ac); // released
        apb(8'h00, 1'b1, 32'h00000007);
        op1 <= 16'h0303;
        op2 <= 16'h0505;
        step(4);
        check_word(result, 32'h000f000f); // split
        apb(8'h00, 1'b1, 32'h00000006);
        op3            <= 16'habcd;
        upper_acc_load <= 1'b1;
        lower_acc_load <= 1'b1;
        step(4);
        check_word(result, 32'habcdabcd); // load
        op3_hold <= 1'b1;
        op3      <= 16'h1111;
        step(4);
        check_word(result, 32'habcdabcd); // op3 held
        op3_hold       <= 1'b0;
        upper_acc_hold <= 1'b1;
        step(4);
        check_word(result, 32'habcd1111); // upper held
        upper_acc_hold <= 1'b0;
        lower_acc_hold <= 1'b1;
        op3            <= 16'h2222;
        step(4);
        check_word(result, 32'h22221111); // lower held
        lower_acc_hold  <= 1'b0;
        upper_acc_reset <= 1'b1;
        step(4);
        check_word(result, 32'h00002222); // upper reset
        lower_acc_reset <= 1'b1;
        step(4);
        check_word(result, 32'h0); // lower reset
        upper_acc_reset <= 1'b0;
        lower_acc_reset <= 1'b0;
        upper_acc_load  <= 1'b0;
        lower_acc_load  <= 1'b0;
        apb(8'h00, 1'b1, 32'h00000016);
        op1 <= 16'h0001;
        op2 <= 16'hffff;
        op3 <= 16'h0000;
        op4 <= 16'h0001;
        step(4);
        check_word(result, 32'h00020000); // sum
        tile_req <= 1'b1;
        step(4);
        check_word(result, 32'h00020001); // tile carry
        tile_req          <= 1'b0;
        upper_add_sub_sel <= 1'b1;
        lower_add_sub_sel <= 1'b1;
        step(4);
        check_word(result, 32'hfffe0002); // difference
        check_bit(tile_carry_out, 1'b1); // borrow out
        check_bit(cascade_carry_out, 1'b1); // borrow out
        apb(8'h00, 1'b1, 32'h00000036);
        casc_req <= 1'b1;
        step(4);
        check_word(result, 32'hfffe0001); // cascade borrow
        op4_hold <= 1'b1;
        op4      <= 16'h0003;
        step(4);
        check_word(result, 32'hfffe0001); // op4 held
        sign_req <= 1'b1;
        step(3);
        check_bit(sign_ext_out_b, 1'b1); // sign passed
        apb(8'h08, 1'b0, 32'h0);
        check_bit(rd[3], 1'b1); // sign flag
        upper_add_sub_sel <= 1'b0;
        lower_add_sub_sel <= 1'b0;
        casc_req          <= 1'b0;
        sign_req          <= 1'b0;
        op4_hold          <= 1'b0;
        apb(8'h00, 1'b1, 32'h00000048);
        op1             <= 16'hfffe;
        op2             <= 16'h0003;
        upper_acc_reset <= 1'b1;
        lower_acc_reset <= 1'b1;
        step(1);
        upper_acc_reset <= 1'b0;
        lower_acc_reset <= 1'b0;
        step(2);
        check_word(result, 32'hfffffffa); // signed mac
        ce <= 1'b0;
        step(2);
        check_word(result, 32'hfffffff4); // mac bypass
        check_bit(sign_ext_out_b, 1'b1); // signed msb
        apb(8'h00, 1'b1, 32'h00000019);
        op1 <= 16'h0001;
        op2 <= 16'h000c;
        ce  <= 1'b1;
        step(1);
        ce <= 1'b0;
        step(1);
        check_word(result, 32'h0); // split acc
        check_bit(tile_carry_out, 1'b1); // split carry
        stop_test();
    end
endmodule // tb
